// *** tsw_pkg.sv ***
// tsw_pkg: constants, field layouts and types for the switch-path block.
// assumes a single 100 MHz clock and the synchronous host request struct below.
package tsw_pkg;

  // ==========================================================================
  // geometry
  localparam int NUM_STREAMS = 16;
  localparam int CH_PER_FRAME = 32;
  localparam int CM_INDEX_W = 9;
  localparam int CM_DEPTH = 512;
  localparam int DM_DEPTH = 2048;

  // ==========================================================================
  // host address map
  localparam logic [13:0] ADDR_CTRL = 14'h0000;
  localparam logic [13:0] ADDR_IMS = 14'h0001;
  localparam logic [13:0] ADDR_CML_BASE = 14'h0800;
  localparam logic [13:0] ADDR_CMH_BASE = 14'h1000;

  // ==========================================================================
  // control_register and internal_mode_select_register fields
  localparam int CTRL_VARIABLE_DELAY_GLOBAL_ENABLE_BIT = 4;
  localparam int CTRL_BPE_BIT = 3;
  localparam int IMS_PAT_LSB = 1;
  localparam int IMS_START_BIT = 0;
  localparam logic [15:0] CTRL_RST = 16'h0000;
  localparam logic [15:0] IMS_RST = 16'h0000;

  // ==========================================================================
  // connection_word_low / connection_word_high fields
  localparam int CML_LAW_EN_BIT = 15;
  localparam int CML_VAR_BIT = 14;
  localparam int CML_SSA_LSB = 9;
  localparam int CML_SCA_LSB = 1;
  localparam int CML_MSG_LSB = 3;
  localparam int CML_SPC_LSB = 1;
  localparam int CML_CMM_BIT = 0;
  localparam logic [1:0] SPC_MESSAGE = 2'h1;
  localparam int CMH_VOICE_BIT = 0;
  localparam int CMH_INLAW_BIT = 1;
  localparam int CMH_OUTLAW_BIT = 2;
  localparam int CMH_W = 5;

  // ==========================================================================
  // data values and delay thresholds
  localparam logic [7:0] IDLE_BYTE = 8'hff;
  localparam logic [7:0] LAW_XOR = 8'h55;
  localparam logic signed [6:0] VAR_EDGE_GAP = 7'sd7;

  // ==========================================================================
  // timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int BP_TIME_NS = 250000;
  localparam int BP_CYCLES = (BP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ==========================================================================
  // types
  typedef enum logic [1:0] {
    BP_IDLE = 2'b00,
    BP_WALK = 2'b01,
    BP_WAIT = 2'b10
  } tsw_bp_state_t;

  typedef struct packed {
    logic cs;
    logic rd;
    logic wr;
    logic [13:0] addr;
    logic [15:0] wdata;
  } tsw_host_req_t;

  typedef struct packed {
    logic [2:0] ck_sync;
    logic [1:0] fp_sync;
    logic [NUM_STREAMS-1:0] sin_s1;
    logic [NUM_STREAMS-1:0] sin_s2;
    logic [7:0] bit_idx;
    logic [1:0] page;
    logic [NUM_STREAMS-1:0][7:0] in_shift;
    logic [NUM_STREAMS-1:0][7:0] out_shift;
    logic [NUM_STREAMS-1:0] out_oe;
    logic [15:0] ctrl;
    logic [15:0] internal_mode_select_register;
    tsw_bp_state_t bp_state;
    logic [CM_INDEX_W-1:0] bp_addr;
    logic [14:0] bp_cnt;
    logic [15:0] rdata;
    logic ready;
  } tsw_state_t;

endpackage

// *** tsw_switch_path.sv ***
// tsw_switch_path: connection memory, delay selection, message output and
// block programming of a 16-stream time-slot interchange path.
// assumes bit clock and frame pulse pins from the link side and a host on clk.
`timescale 1ns/1ns

// Operation
// - bit 14 picks variable or constant delay
// - variable mode sends output as early as possible
// - variable delay page follows n minus m
// - constant delay is two frames plus n-m
// - constant delay spans frame+channel to 3frames-channel
// - constant delay stays selectable with global enable
// - one host access per word, unused bits zero
// - bit 15 low disables law conversion
// - normal mode takes source channel and stream
// - special mode message sends bits 10..3
// - law conversion also works in message mode
// - block program writes pattern, clears everything else
// - block program lasts at least two frames
// - device clears start bit when finished
// - clearing start or enable aborts block program
module tsw_switch_path
  import tsw_pkg::*;
#(
  parameter int BP_MIN_CYCLES = BP_CYCLES
) (
  input wire logic clk, // 100 MHz system clock
  input wire logic rstn, // async reset, active low
  input wire logic bit_clk, // serial bit clock pin
  input wire logic frame_pulse, // frame start pin, high on bit 0
  input wire logic [NUM_STREAMS-1:0] serial_input_stream, // serial data in
  output logic [NUM_STREAMS-1:0] serial_output_stream, // serial data out
  output logic [NUM_STREAMS-1:0] serial_output_stream_oe, // high while driven
  input wire tsw_host_req_t host_req, // host request
  output logic [15:0] host_rdata, // read data
  output logic host_ready // one-cycle answer
);

  localparam logic [14:0] BP_LIMIT = 15'(BP_MIN_CYCLES);

  // ==========================================================================
  // state and memories
  tsw_state_t s_r;
  tsw_state_t s_nxt;
  logic [15:0] cm_low [0:CM_DEPTH-1];
  logic [CMH_W-1:0] cm_high [0:CM_DEPTH-1];
  logic [7:0] dmem [0:DM_DEPTH-1];

  logic bit_edge;
  logic fp_now;
  logic [7:0] edge_idx;
  logic [1:0] edge_pg;
  logic [1:0] prev_pg;
  logic [1:0] const_pg;
  logic [4:0] out_ch;
  logic [NUM_STREAMS-1:0][7:0] out_byte;
  logic [NUM_STREAMS-1:0] out_drive;
  logic cml_we;
  logic cmh_we;
  logic [CM_INDEX_W-1:0] cm_waddr;
  logic [15:0] cml_wdata;
  logic [CMH_W-1:0] cmh_wdata;
  logic dm_we;
  logic host_is_cml;
  logic host_is_cmh;
  logic [CM_INDEX_W-1:0] host_idx;
  logic [15:0] host_rd_val;

  // ==========================================================================
  // frame timing
  // edge detect reads only the second and third sync stages
  assign bit_edge = s_r.ck_sync[1] & ~s_r.ck_sync[2];
  assign fp_now = s_r.fp_sync[1];
  assign edge_idx = fp_now ? 8'h00 : s_r.bit_idx;
  // three pages rotate so constant delay can look two frames back
  assign edge_pg = fp_now ? ((s_r.page == 2'h2) ? 2'h0 : s_r.page + 2'h1) : s_r.page;
  assign prev_pg = (edge_pg == 2'h0) ? 2'h2 : edge_pg - 2'h1;
  assign const_pg = (edge_pg == 2'h2) ? 2'h0 : edge_pg + 2'h1;
  assign out_ch = edge_idx[7:3];

  // ==========================================================================
  // per-stream output byte selection
  for (genvar gs = 0; gs < NUM_STREAMS; gs++) begin : g_out
    logic [15:0] cml;
    logic [CMH_W-1:0] cmh;
    logic [4:0] src_ch;
    logic [3:0] src_st;
    logic signed [6:0] diff;
    logic [1:0] rpage;
    logic [7:0] raw;
    logic use_cur;

    assign cml = cm_low[{4'(gs), out_ch}];
    assign cmh = cm_high[{4'(gs), out_ch}];
    assign src_ch = cml[CML_SCA_LSB +: 5];
    assign src_st = cml[CML_SSA_LSB +: 4];
    assign diff = $signed({2'b00, out_ch}) - $signed({2'b00, src_ch});

    // variable delay takes this frame's byte only when it is already in
    always_comb begin
      use_cur = 1'b0;
      if (diff > VAR_EDGE_GAP) begin
        use_cur = 1'b1;
      end else if (diff == VAR_EDGE_GAP) begin
        use_cur = (4'(gs) >= src_st);
      end
      rpage = const_pg;
      if (cml[CML_VAR_BIT]) begin
        rpage = use_cur ? edge_pg : prev_pg;
      end
    end

    // byte and drive for this output channel
    always_comb begin
      raw = dmem[{rpage, src_st, src_ch}];
      out_drive[gs] = 1'b1;
      out_byte[gs] = raw;
      if (cml[CML_CMM_BIT]) begin
        // only message mode drives; other special codes float the slot
        out_drive[gs] = (cml[CML_SPC_LSB +: 2] == SPC_MESSAGE);
        out_byte[gs] = cml[CML_MSG_LSB +: 8];
      end else if (cml[CML_VAR_BIT] && !s_r.ctrl[CTRL_VARIABLE_DELAY_GLOBAL_ENABLE_BIT]) begin
        out_byte[gs] = IDLE_BYTE;
      end
      // simplified law swap; applies to message data too
      if (cml[CML_LAW_EN_BIT] && cmh[CMH_VOICE_BIT] &&
          (cmh[CMH_INLAW_BIT] != cmh[CMH_OUTLAW_BIT])) begin
        out_byte[gs] = out_byte[gs] ^ LAW_XOR;
      end
    end
  end

  // ==========================================================================
  // host decode
  assign host_is_cml = (host_req.addr[13:CM_INDEX_W] == ADDR_CML_BASE[13:CM_INDEX_W]);
  assign host_is_cmh = (host_req.addr[13:CM_INDEX_W] == ADDR_CMH_BASE[13:CM_INDEX_W]);
  assign host_idx = host_req.addr[CM_INDEX_W-1:0];

  // read mux; narrow words pad with zeros, unmapped reads zero
  always_comb begin
    host_rd_val = 16'h0000;
    if (host_req.addr == ADDR_CTRL) begin
      host_rd_val = s_r.ctrl;
    end else if (host_req.addr == ADDR_IMS) begin
      host_rd_val = s_r.internal_mode_select_register;
    end else if (host_is_cml) begin
      host_rd_val = cm_low[host_idx];
    end else if (host_is_cmh) begin
      host_rd_val = {11'h000, cm_high[host_idx]};
    end
  end

  // ==========================================================================
  // next state
  always_comb begin
    s_nxt = s_r;
    cml_we = 1'b0;
    cmh_we = 1'b0;
    cm_waddr = host_idx;
    cml_wdata = host_req.wdata;
    cmh_wdata = host_req.wdata[CMH_W-1:0];
    dm_we = 1'b0;
    s_nxt.ready = 1'b0;

    // pin synchronisers
    s_nxt.ck_sync = {s_r.ck_sync[1:0], bit_clk};
    s_nxt.fp_sync = {s_r.fp_sync[0], frame_pulse};
    s_nxt.sin_s1 = serial_input_stream;
    s_nxt.sin_s2 = s_r.sin_s1;

    // serial side: shift in, store bytes, load and shift out
    if (bit_edge) begin
      s_nxt.bit_idx = edge_idx + 8'h01;
      s_nxt.page = edge_pg;
      dm_we = (edge_idx[2:0] == 3'h7);
      for (int i = 0; i < NUM_STREAMS; i++) begin
        s_nxt.in_shift[i] = {s_r.in_shift[i][6:0], s_r.sin_s2[i]};
        if (edge_idx[2:0] == 3'h0) begin
          s_nxt.out_shift[i] = out_byte[i];
          s_nxt.out_oe[i] = out_drive[i];
        end else begin
          s_nxt.out_shift[i] = {s_r.out_shift[i][6:0], 1'b0};
        end
      end
    end

    // block program sequencer
    unique case (s_r.bp_state)
      BP_IDLE: begin
        s_nxt.bp_addr = '0;
        s_nxt.bp_cnt = 15'h0000;
      end
      BP_WALK: begin
        cml_we = 1'b1;
        cmh_we = 1'b1;
        cm_waddr = s_r.bp_addr;
        cml_wdata = {13'h0000, s_r.internal_mode_select_register[IMS_PAT_LSB +: 3]};
        cmh_wdata = '0;
        s_nxt.bp_addr = s_r.bp_addr + 9'h001;
        s_nxt.bp_cnt = s_r.bp_cnt + 15'h0001;
        if (s_r.bp_addr == 9'h1ff) begin
          s_nxt.bp_state = BP_WAIT;
        end
      end
      BP_WAIT: begin
        s_nxt.bp_cnt = s_r.bp_cnt + 15'h0001;
        if (s_r.bp_cnt >= BP_LIMIT - 15'h0001) begin
          s_nxt.internal_mode_select_register[IMS_START_BIT] = 1'b0;
          s_nxt.bp_state = BP_IDLE;
        end
      end
      default: begin
        s_nxt.bp_state = BP_IDLE;
      end
    endcase
    // dropping either bit stops the walk where it stands
    if (s_r.bp_state != BP_IDLE &&
        (!s_r.ctrl[CTRL_BPE_BIT] || !s_r.internal_mode_select_register[IMS_START_BIT])) begin
      s_nxt.bp_state = BP_IDLE;
      cml_we = 1'b0;
      cmh_we = 1'b0;
    end

    // host access, one cycle each; a register write lands after the sequencer so it wins
    if (host_req.cs && host_req.rd) begin
      s_nxt.rdata = host_rd_val;
      s_nxt.ready = 1'b1;
    end else if (host_req.cs && host_req.wr) begin
      s_nxt.ready = 1'b1;
      if (host_req.addr == ADDR_CTRL) begin
        s_nxt.ctrl = host_req.wdata;
      end else if (host_req.addr == ADDR_IMS) begin
        s_nxt.internal_mode_select_register = host_req.wdata;
        // launch only on a fresh start with the enable already up
        if (host_req.wdata[IMS_START_BIT] && !s_r.internal_mode_select_register[IMS_START_BIT] &&
            s_r.ctrl[CTRL_BPE_BIT] && s_r.bp_state == BP_IDLE) begin
          s_nxt.bp_state = BP_WALK;
        end
      end else if (s_r.bp_state == BP_IDLE) begin
        // memory writes are dropped while a block program owns the words
        cml_we = host_is_cml;
        cmh_we = host_is_cmh;
      end
    end
  end

  // ==========================================================================
  // registers
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s_r <= '{ctrl: CTRL_RST, internal_mode_select_register: IMS_RST, bp_state: BP_IDLE, default: '0};
    end else begin
      s_r <= s_nxt;
    end
  end

  // memory arrays are not reset; block programming initialises the connection memory, not dmem
  always_ff @(posedge clk) begin
    if (cml_we) begin
      cm_low[cm_waddr] <= cml_wdata;
    end
    if (cmh_we) begin
      cm_high[cm_waddr] <= cmh_wdata;
    end
    if (dm_we) begin
      for (int i = 0; i < NUM_STREAMS; i++) begin
        dmem[{edge_pg, 4'(i), edge_idx[7:3]}] <= {s_r.in_shift[i][6:0], s_r.sin_s2[i]};
      end
    end
  end

  // ==========================================================================
  // outputs
  for (genvar go = 0; go < NUM_STREAMS; go++) begin : g_pin
    assign serial_output_stream[go] = s_r.out_shift[go][7];
  end
  assign serial_output_stream_oe = s_r.out_oe;
  assign host_rdata = s_r.rdata;
  assign host_ready = s_r.ready;

endmodule

// *** tsw_monitor.sv ***
// tsw_monitor: port-level assertions for the switch-path block.
// assumes a bit clock half period of at least 6 clk cycles.
`timescale 1ns/1ns
module tsw_monitor
  import tsw_pkg::*;
(
  input wire logic clk, // system clock
  input wire logic rstn, // async reset, active low
  input wire logic bit_clk, // serial bit clock pin
  input wire logic [NUM_STREAMS-1:0] serial_output_stream, // serial out
  input wire tsw_host_req_t host_req, // host request
  input wire logic [15:0] host_rdata, // read data
  input wire logic host_ready // answer pulse
);
  // ====
  // request decode, single clock domain
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  logic take, rd_go, wr_ctl, rd_ctl, clr_ims, rd_ims;
  assign take = host_req.cs && (host_req.rd || host_req.wr);
  assign rd_go = host_req.cs && host_req.rd;
  assign wr_ctl = take && !host_req.rd && host_req.addr == ADDR_CTRL;
  assign rd_ctl = rd_go && host_req.addr == ADDR_CTRL;
  assign clr_ims = take && !host_req.rd && host_req.addr == ADDR_IMS && !host_req.wdata[0];
  assign rd_ims = rd_go && host_req.addr == ADDR_IMS;
  // ====
  // host port
  property p_ready; take |=> host_ready; endproperty
  a_ready: assert property (p_ready) else $error("no answer after request");
  property p_quiet; !take |=> !host_ready; endproperty
  a_quiet: assert property (p_quiet) else $error("answer without request");
  property p_hold; !rd_go |=> $stable(host_rdata); endproperty
  a_hold: assert property (p_hold) else $error("read data moved without read");
  property p_cmh; rd_go && host_req.addr[13:9] == 5'h08 |=> host_rdata[15:5] == 11'h000; endproperty
  a_cmh: assert property (p_cmh) else $error("high word upper bits not zero");
  property p_unmap;
    rd_go && host_req.addr[13:11] == 3'h0 && host_req.addr[10:1] != 10'h000 |=> host_rdata == 16'h0000;
  endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  // enable bits are never changed by the device itself
  property p_ctl; wr_ctl ##2 rd_ctl |=> host_rdata[4:3] == $past(host_req.wdata[4:3], 3); endproperty
  a_ctl: assert property (p_ctl) else $error("control bits lost");
  property p_ims; clr_ims ##2 rd_ims |=> !host_rdata[0]; endproperty
  a_ims: assert property (p_ims) else $error("start bit set after clear");
  // serial output may only move shortly after a bit clock rise
  property p_edge; $changed(serial_output_stream) |-> $past(bit_clk, 2); endproperty
  a_edge: assert property (p_edge) else $error("serial output off bit edge");
  c_cmh: cover property (rd_go && host_req.addr[13:9] == 5'h08);
  c_clr: cover property (clr_ims);
  c_out: cover property ($rose(serial_output_stream[0]));
endmodule
bind tsw_switch_path tsw_monitor mon_u (.clk(clk), .rstn(rstn), .bit_clk(bit_clk),
  .serial_output_stream(serial_output_stream), .host_req(host_req), .host_rdata(host_rdata),
  .host_ready(host_ready));

// *** tsw_link_model.sv ***
// tsw_link_model: far-end serial devices with bit clock and frame pulse.
// assumes the bench reads bn and fno on bit clock falling edges.
`timescale 1ns/1ns
module tsw_link_model
  import tsw_pkg::*;
#(
  parameter int HALF_NS = 60
) (
  output logic bit_clk, // serial bit clock
  output logic frame_pulse, // high on bit 0
  output logic [NUM_STREAMS-1:0] serial_input_stream, // data to switch
  output logic [7:0] bn, // bit index on the wire
  output int fno // frame count
);
  logic [7:0] nb, b;
  int nf;
  function automatic logic [7:0] pat(int f, int s, int c);
    return 8'(f * 29 + s * 13 + c * 5);
  endfunction
  // free running clock, kept off the system clock edges
  initial begin
    bit_clk = 1'b0;
    // pins start low: the first bit clock rise comes before the first fall,
    // and an unknown frame pulse there would poison the page counter for good
    frame_pulse = 1'b0;
    serial_input_stream = '0;
    bn = 8'hff;
    fno = 0;
    #3;
    forever #HALF_NS bit_clk = ~bit_clk;
  end
  // next bit set on the fall so it is steady around the rise
  always @(negedge bit_clk) begin
    nb = bn + 8'h01;
    nf = fno + int'(bn == 8'hff);
    for (int s = 0; s < NUM_STREAMS; s++) begin
      b = pat(nf, s, int'(nb[7:3]));
      serial_input_stream[s] <= b[3'h7 - nb[2:0]];
    end
    frame_pulse <= nb == 8'h00;
    bn <= nb;
    fno <= nf;
  end
endmodule

// *** test_tsw_switch_path.sv ***
// test_tsw_switch_path: self-checking bench for the switch-path block.
// assumes the link model on the serial side; host driven from here.
`timescale 1ns/1ns
module test_tsw_switch_path
  import tsw_pkg::*;
;
  localparam int BPM = 600;
  logic clk, rstn, bit_clk, frame_pulse, host_ready, chk_on, variable_delay_global_enable;
  logic [NUM_STREAMS-1:0] sin, sout, soe;
  tsw_host_req_t host_req;
  logic [15:0] host_rdata, q;
  logic [15:0] cml [32];
  logic [4:0] cmh [32];
  logic [7:0] bn, cap;
  logic [8:0] e9;
  logic [2:0] p;
  logic [8:0] a;
  int fno, f0, t, n_errors, num_checks;
  tsw_switch_path #(.BP_MIN_CYCLES(BPM)) dut_u (.clk(clk), .rstn(rstn), .bit_clk(bit_clk),
    .frame_pulse(frame_pulse), .serial_input_stream(sin), .serial_output_stream(sout),
    .serial_output_stream_oe(soe), .host_req(host_req), .host_rdata(host_rdata), .host_ready(host_ready));
  tsw_link_model link_u (.bit_clk(bit_clk), .frame_pulse(frame_pulse), .serial_input_stream(sin),
    .bn(bn), .fno(fno));
  // ====
  // checking and host tasks
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // one edge per request; answer sampled just after the next edge
  task automatic acc(input logic w, input logic [13:0] ad, input logic [15:0] d);
    @(posedge clk);
    #1 host_req = '{1'b1, ~w, w, ad, d};
    @(posedge clk);
    #1 q = host_rdata;
    host_req.cs = 1'b0;
    chk(16'(host_ready), 16'h0001, "ready");
  endtask
  task automatic rdc(input logic [13:0] ad, input logic [15:0] e, input string w);
    acc(1'b0, ad, 16'h0000);
    chk(q, e, w);
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // ====
  // reference model of stream 0
  function automatic logic [7:0] pat(int f, int s, int c);
    return 8'(f * 29 + s * 13 + c * 5);
  endfunction
  function automatic logic [15:0] cw(logic l, logic v, int s, int m);
    return {l, v, 5'(s), 8'(m), 1'b0};
  endfunction
  // bit 8 of the result marks a floating slot
  function automatic logic [8:0] expv(int f, int n);
    logic [15:0] w;
    logic [7:0] b;
    int s, d;
    w = cml[n];
    s = int'(w[12:9]);
    d = n - int'(w[5:1]);
    if (w[0]) b = w[10:3];
    else if (!w[14]) b = pat(f - 2, s, int'(w[5:1]));
    else if (!variable_delay_global_enable) b = IDLE_BYTE;
    else b = pat((d > 7 || (d == 7 && s == 0)) ? f : f - 1, s, int'(w[5:1]));
    if (w[15] && cmh[n][0] && cmh[n][1] != cmh[n][2]) b = b ^ LAW_XOR;
    return {w[0] && w[2:1] != SPC_MESSAGE, b};
  endfunction
  // ====
  // clock, watchdog and stream 0 capture
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    #800000;
    n_errors++;
    $display("mismatch watchdog expected finish seen timeout");
    give_verdict();
  end
  always @(negedge bit_clk) begin
    cap = {cap[6:0], sout[0]};
    if (chk_on && bn[2:0] == 3'h7) begin
      e9 = expv(fno, int'(bn[7:3]));
      chk(16'(soe[0]), 16'(!e9[8]), "oe");
      if (!e9[8]) chk(16'(cap), 16'(e9[7:0]), "byte");
    end
  end
  // ====
  // main sequence
  initial begin
    host_req = '0;
    rstn = 1'b0;
    chk_on = 1'b0;
    variable_delay_global_enable = 1'b0;
    n_errors = 0;
    num_checks = 0;
    void'($urandom(48));
    repeat (2) @(posedge clk);
    #1 rstn = 1'b1;
    rdc(ADDR_CTRL, CTRL_RST, "ctrl");
    rdc(ADDR_IMS, IMS_RST, "ims");
    acc(1'b1, 14'h0400, 16'hffff);
    rdc(14'h0400, 16'h0000, "unmapped");
    $display("test reset done");
    // block program: aborted once, then run to the end
    p = 3'($urandom());
    acc(1'b1, ADDR_CTRL, 16'h0008);
    acc(1'b1, ADDR_IMS, {12'h000, p, 1'b1});
    acc(1'b1, ADDR_IMS, {12'h000, p, 1'b0});
    rdc(ADDR_IMS, {12'h000, p, 1'b0}, "abort");
    acc(1'b1, ADDR_IMS, {12'h000, p, 1'b1});
    t = 0;
    do begin
      acc(1'b0, ADDR_IMS, 16'h0000);
      t += 2;
    end while (q[0] && t < 4 * BPM);
    chk(16'(t >= BPM), 16'h0001, "bp length");
    chk(q, {12'h000, p, 1'b0}, "start cleared");
    rdc(ADDR_CTRL, 16'h0008, "enable kept");
    for (int i = 0; i < 4; i++) begin
      a = 9'($urandom());
      rdc(ADDR_CML_BASE | 14'(a), {13'h0000, p}, "cml");
      rdc(ADDR_CMH_BASE | 14'(a), 16'h0000, "cmh");
    end
    acc(1'b1, ADDR_CTRL, 16'h0000);
    $display("test block program done");
    // fixed slots for each mode and variable delay edge case, the rest random or from stream 0 channel 0
    foreach (cml[i]) begin
      cml[i] = (i >= 12 && i < 20) ? cw(1'b0, 1'($urandom()), $urandom() % 16, $urandom() % 32) : 16'h0000;
      cmh[i] = 5'h00;
    end
    cml[2] = cw(1'b0, 1'b0, 3, 5);
    cml[3] = cw(1'b0, 1'b1, 2, 9);
    cml[10] = cw(1'b0, 1'b1, 4, 2);
    cml[20] = cw(1'b0, 1'b1, 1, 13);
    cml[21] = cw(1'b0, 1'b1, 0, 14);
    cml[8] = cw(1'b1, 1'b0, 6, 30);
    cmh[8] = 5'h03;
    cml[9] = cw(1'b1, 1'b1, 7, 1);
    cmh[9] = 5'h02;
    cml[5] = {5'h00, 8'($urandom()), 3'h3};
    cml[6] = {5'h10, 8'($urandom()), 3'h3};
    cmh[6] = 5'h05;
    cml[7] = 16'h0005;
    foreach (cml[i]) begin
      acc(1'b1, ADDR_CMH_BASE | 14'(i), {11'h7ff, cmh[i]});
      acc(1'b1, ADDR_CML_BASE | 14'(i), cml[i]);
    end
    rdc(ADDR_CMH_BASE | 14'h0006, 16'(cmh[6]), "cmh");
    rdc(ADDR_CML_BASE | 14'h0006, cml[6], "cml");
    for (int v = 1; v >= 0; v--) begin
      variable_delay_global_enable = v[0];
      acc(1'b1, ADDR_CTRL, {11'h000, v[0], 4'h0});
      f0 = fno;
      wait (fno == f0 + 3);
      chk_on = 1'b1;
      wait (fno == f0 + 6);
      chk_on = 1'b0;
      $display("test traffic with variable enable %0d done", v);
    end
    give_verdict();
  end
endmodule
